// ===== hbcc_top.sv
// Digital core of a single half-bridge gate driver with fixed off-time chopping.
// Assumes analog comparators and gate-off detectors feed it; pins are asynchronous.
// Overview of operation
// - Strap high gives unregulated PWM; strap floating gives regulated PWM.
// - Power-up enables digital regulator, then latches strap, then analog regulator.
// - Strap is captured only at power-up or sleep exit, later changes ignored.
// - Fault indicator is pulled low on any fault, released otherwise.
// - Current at chopping threshold forces brake until off-time expires.
// - Sense input is ignored for a blanking time after current enable.
// - Chop decision compares gained shunt voltage with reference; fixed gain 19.8.
// - Configurable variant offers gains 10, 19.8, 39.4 or 78.
// - Unregulated mode never chops current.
// - Regulated mode with both inputs high brakes on the low side.
// - Sense differential above 1 V flags overcurrent.
// - With sample-hold enabled, amplifier output is high impedance in brake.
// - Each output change gets a peak-current window, then a hold current.
// - High-side turn-on holds the low gate with a strong pulldown.
// - No FET turns on until the opposite one is detected off.
// - Peak sink current is about twice the source current.
// - Grounded drive pin selects 10 mA source, 20 mA sink.
// - Open drive pin selects 155 mA high, 130 mA low source.
`timescale 1ns/1ps
`default_nettype none
module hbcc_top
   import hbcc_pkg::*;
#(
   parameter int         TOFF_T_NS   = TOFF_NS,
   parameter int         BLANK_T_NS  = BLANK_NS,
   parameter int         DRIVE_T_NS  = DRIVE_NS,
   parameter int         DEAD_T_NS   = DEAD_NS,
   parameter int         PWR_T_NS    = PWR_STEP_NS,
   parameter logic       CONFIG_GAIN = 1'b1
) (
   input  wire logic          core_clk_in,
   input  wire logic          arst_n_in,
   input  wire hbcc_pins_t    pins_in,
   input  wire logic [AW-1:0] reg_addr_in,
   input  wire logic [DW-1:0] reg_wdata_in,
   input  wire logic          reg_wr_in,
   input  wire logic          reg_rd_in,
   output var  logic [DW-1:0] reg_rdata_out,
   output var  logic          digital_regulator_en_out,
   output var  logic          analog_regulator_en_out,
   output var  hbcc_gate_t    gate_out,
   output var  logic          fault_indicator_low_out,
   output var  logic          fault_indicator_low_oe_out,
   output var  logic          amp_hiz_out,
   output var  logic [1:0]    gain_code_out,
   output var  logic [9:0]    gain_x10_out,
   output var  logic [9:0]    hs_source_ma_out,
   output var  logic [9:0]    ls_source_ma_out,
   output var  logic [9:0]    hs_sink_ma_out,
   output var  logic [9:0]    ls_sink_ma_out
);
   localparam logic [CW-1:0] TOFF_CYC  = hbcc_cycles(TOFF_T_NS);
   localparam logic [CW-1:0] BLANK_CYC = hbcc_cycles(BLANK_T_NS);
   localparam logic [CW-1:0] DRIVE_CYC = hbcc_cycles(DRIVE_T_NS);
   localparam logic [CW-1:0] DEAD_CYC  = hbcc_cycles(DEAD_T_NS);
   localparam logic [CW-1:0] PWR_CYC   = hbcc_cycles(PWR_T_NS);
   localparam logic [CW-1:0] CNT_ONE   = 12'h001;

   logic        rst_meta_r;
   logic        rst_n_r;
   hbcc_pins_t  pin_s;

   // Async assert, sync release
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rst_meta_r <= 1'b0;
         rst_n_r    <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n_r    <= rst_meta_r;
      end
   end

   hbcc_sync #(.W($bits(hbcc_pins_t))) u_sync (
      .clk_in   (core_clk_in),
      .rst_n_in (rst_n_r),
      .d_in     (pins_in),
      .q_out    (pin_s)
   );

   hbcc_pwr_t   pw_r, pw_nxt;
   logic [CW-1:0] pw_cnt_r, pw_cnt_nxt;
   logic        mode_unreg_r, mode_unreg_nxt;
   hbcc_chop_t  ch_r, ch_nxt;
   logic [CW-1:0] ch_cnt_r, ch_cnt_nxt;
   hbcc_gseq_t  gs_r, gs_nxt;
   hbcc_leg_t   leg_r, leg_nxt;
   logic [CW-1:0] gs_cnt_r, gs_cnt_nxt;
   logic [CW-1:0] peak_cnt_r, peak_cnt_nxt;
   logic [1:0]  gain_sel_r;
   logic        sample_hold_enable_r;
   logic        ocp_flag_r, illegal_flag_r;
   logic        fault_r;
   logic        brake_r;

   // Power-up sequencing; strap is sampled only in the latch step
   always_comb begin
      pw_nxt         = pw_r;
      pw_cnt_nxt     = pw_cnt_r + CNT_ONE;
      mode_unreg_nxt = mode_unreg_r;
      if (!pin_s.sleep_n) begin
         pw_nxt     = PW_OFF;
         pw_cnt_nxt = '0;
      end else begin
         case (pw_r)
            PW_OFF: begin
               pw_nxt     = PW_DIG;
               pw_cnt_nxt = '0;
            end
            PW_DIG: begin
               if (pw_cnt_r == PWR_CYC - CNT_ONE) begin
                  pw_nxt     = PW_LATCH;
                  pw_cnt_nxt = '0;
               end
            end
            PW_LATCH: begin
               mode_unreg_nxt = pin_s.mode_strap_high;
               pw_nxt         = PW_RUN;
               pw_cnt_nxt     = '0;
            end
            default: begin
               pw_cnt_nxt = '0;
            end
         endcase
      end
   end

   wire logic run = (pw_r == PW_RUN);
   wire logic in1 = pin_s.first_control_input;
   wire logic in2 = pin_s.second_control_input;
   wire logic regulated = run && !mode_unreg_r;
   // Inputs outside the mode's table are a fault
   wire logic illegal = run && (mode_unreg_r ? in2 : (!in1 && in2));
   wire logic fault_any = illegal || pin_s.ext_fault || pin_s.sense_overcurrent;
   wire logic bridge_block = !run || illegal || pin_s.ext_fault;

   hbcc_leg_t leg_in;
   assign leg_in = mode_unreg_r ? (in1 ? LEG_HIGH : LEG_LOW) :
                   (in1 ? (in2 ? LEG_LOW : LEG_HIGH) : LEG_OFF);

   wire logic want_high = regulated && !bridge_block && (leg_in == LEG_HIGH);

   // One counter times blanking and off-time
   always_comb begin
      ch_nxt     = ch_r;
      ch_cnt_nxt = ch_cnt_r + CNT_ONE;
      case (ch_r)
         CH_IDLE: begin
            ch_cnt_nxt = '0;
            if (want_high) begin
               ch_nxt = CH_BLANK;
            end
         end
         CH_BLANK: begin
            if (!want_high) begin
               ch_nxt     = CH_IDLE;
               ch_cnt_nxt = '0;
            end else if (ch_cnt_r == BLANK_CYC - CNT_ONE) begin
               ch_nxt     = CH_SENSE;
               ch_cnt_nxt = '0;
            end
         end
         CH_SENSE: begin
            ch_cnt_nxt = '0;
            if (!want_high) begin
               ch_nxt = CH_IDLE;
            end else if (pin_s.chop_compare) begin
               ch_nxt = CH_OFF;
            end
         end
         default: begin
            if (!regulated || bridge_block) begin
               ch_nxt     = CH_IDLE;
               ch_cnt_nxt = '0;
            end else if (ch_cnt_r == TOFF_CYC - CNT_ONE) begin
               ch_nxt     = want_high ? CH_BLANK : CH_IDLE;
               ch_cnt_nxt = '0;
            end
         end
      endcase
   end

   hbcc_leg_t target;
   assign target = bridge_block ? LEG_OFF :
                   (ch_r == CH_OFF) ? LEG_LOW : leg_in;

   wire logic opp_off = (target == LEG_HIGH) ? pin_s.low_gate_off :
                        (target == LEG_LOW) ? pin_s.high_gate_off : 1'b1;
   wire logic dead_done = (gs_cnt_r >= DEAD_CYC - CNT_ONE);

   // Break-before-make on the opposite gate-off flag
   always_comb begin
      gs_nxt       = gs_r;
      leg_nxt      = leg_r;
      gs_cnt_nxt   = '0;
      peak_cnt_nxt = (peak_cnt_r != '0) ? peak_cnt_r - CNT_ONE : '0;
      case (gs_r)
         GS_STEADY: begin
            if (target != leg_r) begin
               if (leg_r != LEG_OFF) begin
                  leg_nxt      = LEG_OFF;
                  peak_cnt_nxt = DRIVE_CYC;
               end
               gs_nxt = GS_WAIT;
            end
         end
         default: begin
            gs_cnt_nxt = dead_done ? gs_cnt_r : gs_cnt_r + CNT_ONE;
            if (target == LEG_OFF) begin
               gs_nxt = GS_STEADY;
            end else if (opp_off && dead_done) begin
               leg_nxt      = target;
               peak_cnt_nxt = DRIVE_CYC;
               gs_nxt       = GS_STEADY;
            end
         end
      endcase
   end

   hbcc_gate_t gate_nxt;
   assign gate_nxt.hs_on = (leg_nxt == LEG_HIGH);
   assign gate_nxt.ls_on = (leg_nxt == LEG_LOW);
   assign gate_nxt.peak = (peak_cnt_nxt != '0);
   assign gate_nxt.ls_strong = gate_nxt.hs_on && gate_nxt.peak;

   wire logic brake_nxt = regulated && (leg_nxt == LEG_LOW);
   wire logic [1:0] gain_eff = CONFIG_GAIN ? gain_sel_r : GAIN_FIXED;

   // Register port decode
   wire logic wr_ctrl = reg_wr_in && (reg_addr_in == REG_CTRL);
   wire logic wr_status = reg_wr_in && (reg_addr_in == REG_STATUS);
   logic [DW-1:0] rd_mux;
   always_comb begin
      rd_mux = '0;
      if (reg_addr_in == REG_CTRL) begin
         rd_mux[CTRL_GAIN_LSB +: 2] = gain_sel_r;
         rd_mux[CTRL_SAMPLE_HOLD_ENABLE_BIT]     = sample_hold_enable_r;
      end else if (reg_addr_in == REG_STATUS) begin
         rd_mux[ST_MODE_BIT]       = mode_unreg_r;
         rd_mux[ST_BRAKE_BIT]      = brake_r;
         rd_mux[ST_FAULT_BIT]      = fault_r;
         rd_mux[ST_OCP_BIT]        = ocp_flag_r;
         rd_mux[ST_ILLEGAL_BIT]    = illegal_flag_r;
         rd_mux[ST_LEG_LSB +: 2]   = leg_r;
      end
   end

   // Sticky flags: a new event wins over a write-one clear
   wire logic ocp_nxt = pin_s.sense_overcurrent ||
                        (ocp_flag_r && !(wr_status && reg_wdata_in[ST_OCP_BIT]));
   wire logic ill_nxt = illegal ||
                        (illegal_flag_r && !(wr_status && reg_wdata_in[ST_ILLEGAL_BIT]));

   always_ff @(posedge core_clk_in or negedge rst_n_r) begin
      if (!rst_n_r) begin
         pw_r         <= PW_OFF;
         pw_cnt_r     <= '0;
         mode_unreg_r <= 1'b0;
         ch_r         <= CH_IDLE;
         ch_cnt_r     <= '0;
         gs_r         <= GS_STEADY;
         leg_r        <= LEG_OFF;
         gs_cnt_r     <= '0;
         peak_cnt_r   <= '0;
      end else begin
         pw_r         <= pw_nxt;
         pw_cnt_r     <= pw_cnt_nxt;
         mode_unreg_r <= mode_unreg_nxt;
         ch_r         <= ch_nxt;
         ch_cnt_r     <= ch_cnt_nxt;
         gs_r         <= gs_nxt;
         leg_r        <= leg_nxt;
         gs_cnt_r     <= gs_cnt_nxt;
         peak_cnt_r   <= peak_cnt_nxt;
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_n_r) begin
      if (!rst_n_r) begin
         gain_sel_r     <= GAIN_RST;
         sample_hold_enable_r        <= 1'b0;
         ocp_flag_r     <= 1'b0;
         illegal_flag_r <= 1'b0;
         reg_rdata_out  <= '0;
      end else begin
         if (wr_ctrl) begin
            gain_sel_r <= reg_wdata_in[CTRL_GAIN_LSB +: 2];
            sample_hold_enable_r    <= reg_wdata_in[CTRL_SAMPLE_HOLD_ENABLE_BIT];
         end
         ocp_flag_r     <= ocp_nxt;
         illegal_flag_r <= ill_nxt;
         reg_rdata_out  <= reg_rd_in ? rd_mux : '0;
      end
   end

   // Registered outputs
   always_ff @(posedge core_clk_in or negedge rst_n_r) begin
      if (!rst_n_r) begin
         digital_regulator_en_out   <= 1'b0;
         analog_regulator_en_out    <= 1'b0;
         gate_out                   <= '0;
         fault_r                    <= 1'b0;
         brake_r                    <= 1'b0;
         fault_indicator_low_out    <= 1'b0;
         fault_indicator_low_oe_out <= 1'b0;
         amp_hiz_out                <= 1'b0;
      end else begin
         digital_regulator_en_out   <= (pw_nxt != PW_OFF);
         analog_regulator_en_out    <= (pw_nxt == PW_RUN);
         gate_out                   <= gate_nxt;
         fault_r                    <= fault_any;
         brake_r                    <= brake_nxt;
         fault_indicator_low_out    <= 1'b0;
         fault_indicator_low_oe_out <= fault_any;
         amp_hiz_out                <= sample_hold_enable_r && brake_nxt;
      end
   end

   // Codes above the top level clip to it
   wire logic [2:0] lvl_clip = (pin_s.gate_current_select > DRV_LEVEL_MAX) ?
                               DRV_LEVEL_MAX : pin_s.gate_current_select;
   wire logic [9:0] hs_src = hbcc_src_ma(lvl_clip, 1'b1);
   wire logic [9:0] ls_src = hbcc_src_ma(lvl_clip, 1'b0);

   // Sink is twice the source
   always_ff @(posedge core_clk_in or negedge rst_n_r) begin
      if (!rst_n_r) begin
         gain_code_out    <= GAIN_RST;
         gain_x10_out     <= '0;
         hs_source_ma_out <= '0;
         ls_source_ma_out <= '0;
         hs_sink_ma_out   <= '0;
         ls_sink_ma_out   <= '0;
      end else begin
         gain_code_out    <= gain_eff;
         gain_x10_out     <= hbcc_gain_x10(gain_eff);
         hs_source_ma_out <= hs_src;
         ls_source_ma_out <= ls_src;
         hs_sink_ma_out   <= {hs_src[8:0], 1'b0};
         ls_sink_ma_out   <= {ls_src[8:0], 1'b0};
      end
   end

endmodule
`default_nettype wire

// ===== hbcc_pkg.sv
// Shared constants, types and lookup functions for the half-bridge chop control.
// Assumes a single 20 MHz core clock and a plain strobe register port.
package hbcc_pkg;

   localparam int CLK_MHZ = 20;
   localparam int NS_PER_US = 1000;
   localparam int CW = 12;

   localparam int TOFF_NS = 25000;
   localparam int BLANK_NS = 2000;
   localparam int DRIVE_NS = 2000;
   localparam int DEAD_NS = 240;
   localparam int PWR_STEP_NS = 1000;

   localparam int AW = 8;
   localparam int DW = 32;
   localparam logic [AW-1:0] REG_CTRL = 8'h00;
   localparam logic [AW-1:0] REG_STATUS = 8'h04;

   localparam int CTRL_GAIN_LSB = 0;
   localparam int CTRL_SAMPLE_HOLD_ENABLE_BIT = 2;
   localparam int ST_MODE_BIT = 0;
   localparam int ST_BRAKE_BIT = 1;
   localparam int ST_FAULT_BIT = 2;
   localparam int ST_OCP_BIT = 3;
   localparam int ST_ILLEGAL_BIT = 4;
   localparam int ST_LEG_LSB = 5;

   localparam logic [1:0] GAIN_RST = 2'h1;
   localparam logic [1:0] GAIN_FIXED = 2'h1;
   localparam logic [2:0] DRV_LEVEL_MAX = 3'h5;

   typedef enum logic [1:0] {LEG_OFF, LEG_HIGH, LEG_LOW} hbcc_leg_t;
   typedef enum logic [1:0] {PW_OFF, PW_DIG, PW_LATCH, PW_RUN} hbcc_pwr_t;
   typedef enum logic [1:0] {CH_IDLE, CH_BLANK, CH_SENSE, CH_OFF} hbcc_chop_t;
   typedef enum logic {GS_STEADY, GS_WAIT} hbcc_gseq_t;

   // Asynchronous pin inputs
   typedef struct packed {
      logic       first_control_input;
      logic       second_control_input;
      logic       sleep_n;
      logic       mode_strap_high;
      logic       chop_compare;
      logic       sense_overcurrent;
      logic       ext_fault;
      logic       high_gate_off;
      logic       low_gate_off;
      logic [2:0] gate_current_select;
   } hbcc_pins_t;

   typedef struct packed {
      logic hs_on;
      logic ls_on;
      logic peak;
      logic ls_strong;
   } hbcc_gate_t;

   // Least time in cycles, rounded up, never below one
   function automatic logic [CW-1:0] hbcc_cycles(input int ns);
      int c;
      c = (ns * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
      if (c < 1) begin
         c = 1;
      end
      return CW'(c);
   endfunction

   // Gain in tenths of V/V
   function automatic logic [9:0] hbcc_gain_x10(input logic [1:0] code);
      case (code)
         2'h0: return 10'h064;
         2'h1: return 10'h0c6;
         2'h2: return 10'h18a;
         default: return 10'h30c;
      endcase
   endfunction

   // Source current in mA at 13.5 V supply; level 0 is pin grounded, 3 is open
   function automatic logic [9:0] hbcc_src_ma(input logic [2:0] lvl, input logic hs);
      case (lvl)
         3'h0: return 10'h00a;
         3'h1: return 10'h014;
         3'h2: return hs ? 10'h032 : 10'h02d;
         3'h3: return hs ? 10'h09b : 10'h082;
         3'h4: return hs ? 10'h0d2 : 10'h0b4;
         default: return hs ? 10'h104 : 10'h0e1;
      endcase
   endfunction

endpackage

// ===== hbcc_sync.sv
// Two-flop synchroniser array for the pin inputs.
// Assumes the reset given is already released synchronously.
`timescale 1ns/1ps
`default_nettype none
module hbcc_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_in,
   input  wire logic         rst_n_in,
   input  wire logic [W-1:0] d_in,
   output var  logic [W-1:0] q_out
);
   logic [W-1:0] meta_r;

   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               meta_r[i] <= 1'b0;
               q_out[i]  <= 1'b0;
            end else begin
               meta_r[i] <= d_in[i];
               q_out[i]  <= meta_r[i];
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

// ===== hbcc_top_asserts.sv
// Port-level checks for the half-bridge chop control core.
// Assumes binding onto hbcc_top.
`timescale 1ns/1ps
`default_nettype none
module hbcc_top_asserts
   import hbcc_pkg::*;
#(
   parameter int DRIVE_T_NS = DRIVE_NS
) (
   input wire logic          core_clk_in,
   input wire logic          arst_n_in,
   input wire hbcc_pins_t    pins_in,
   input wire logic          digital_regulator_en_out,
   input wire logic          analog_regulator_en_out,
   input wire hbcc_gate_t    gate_out,
   input wire logic          fault_indicator_low_out,
   input wire logic          fault_indicator_low_oe_out,
   input wire logic [1:0]    gain_code_out,
   input wire logic [9:0]    gain_x10_out,
   input wire logic [9:0]    hs_source_ma_out,
   input wire logic [9:0]    ls_source_ma_out,
   input wire logic [9:0]    hs_sink_ma_out,
   input wire logic [9:0]    ls_sink_ma_out
);
   localparam int DRV_CYC = (DRIVE_T_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
   localparam logic [9:0] GAIN_REF [4] = '{10'h064, 10'h0c6, 10'h18a, 10'h30c};
   // Outputs valid once the reset copy lets go
   logic [3:0]    live_r;
   logic [CW-1:0] peak_cnt_r;
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         live_r     <= 4'h0;
         peak_cnt_r <= '0;
      end else begin
         live_r     <= {live_r[2:0], 1'b1};
         peak_cnt_r <= !gate_out.peak ? '0 : (!$stable(gate_out.hs_on) ||
                       !$stable(gate_out.ls_on)) ? CW'(1) : peak_cnt_r + CW'(1);
      end
   end
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (!arst_n_in);
   sequence s_hs_launch;
      gate_out.peak && gate_out.ls_strong && !gate_out.ls_on;
   endsequence
   sequence s_ext_fault_held;
      (live_r[3] && pins_in.ext_fault) [*4];
   endsequence
   a_analog_after_dig: assert property ($rose(analog_regulator_en_out) |->
      digital_regulator_en_out && $past(digital_regulator_en_out, 3))
      else $error("analog regulator enabled too early");
   a_analog_needs_dig: assert property (analog_regulator_en_out |-> digital_regulator_en_out)
      else $error("analog regulator on without digital");
   a_no_shoot_through: assert property (!(gate_out.hs_on && gate_out.ls_on))
      else $error("both gates on");
   a_hs_after_ls: assert property ($rose(gate_out.hs_on) |-> $past(!gate_out.ls_on, 2))
      else $error("high gate on without dead time");
   a_ls_after_hs: assert property ($rose(gate_out.ls_on) |-> $past(!gate_out.hs_on, 2))
      else $error("low gate on without dead time");
   a_hs_peak_pull: assert property ($rose(gate_out.hs_on) |-> s_hs_launch)
      else $error("high turn-on lacks peak or pulldown");
   a_strong_pull: assert property (gate_out.ls_strong |-> gate_out.hs_on && gate_out.peak)
      else $error("strong pulldown outside high turn-on");
   a_peak_bound: assert property (peak_cnt_r <= CW'(DRV_CYC))
      else $error("peak window too long");
   a_sink_double: assert property (hs_sink_ma_out == {hs_source_ma_out[8:0], 1'b0} &&
      ls_sink_ma_out == {ls_source_ma_out[8:0], 1'b0})
      else $error("sink current not twice source");
   a_gain_table: assert property (live_r[3] |-> gain_x10_out == GAIN_REF[gain_code_out])
      else $error("gain value does not match code");
   a_fault_drive: assert property (s_ext_fault_held |-> fault_indicator_low_oe_out)
      else $error("fault pin not driven on fault");
   a_fault_level: assert property (!fault_indicator_low_out)
      else $error("fault pin drives high");
endmodule
bind hbcc_top hbcc_top_asserts #(.DRIVE_T_NS(DRIVE_T_NS)) u_chk (
   .core_clk_in(core_clk_in), .arst_n_in(arst_n_in), .pins_in(pins_in),
   .digital_regulator_en_out(digital_regulator_en_out),
   .analog_regulator_en_out(analog_regulator_en_out), .gate_out(gate_out),
   .fault_indicator_low_out(fault_indicator_low_out),
   .fault_indicator_low_oe_out(fault_indicator_low_oe_out),
   .gain_code_out(gain_code_out), .gain_x10_out(gain_x10_out),
   .hs_source_ma_out(hs_source_ma_out), .ls_source_ma_out(ls_source_ma_out),
   .hs_sink_ma_out(hs_sink_ma_out), .ls_sink_ma_out(ls_sink_ma_out));
`default_nettype wire

// ===== hbcc_fet_model.sv
// External FET pair: reports a gate off some cycles after its command drops.
// Assumes gate commands from hbcc_top; slow_in mimics a large gate charge.
`timescale 1ns/1ps
`default_nettype none
module hbcc_fet_model
   import hbcc_pkg::*;
(
   input  wire logic       clk_in,
   input  wire logic       rst_n_in,
   input  wire logic       slow_in,
   input  wire hbcc_gate_t gate_in,
   output var  logic       high_gate_off_out,
   output var  logic       low_gate_off_out
);
   logic [3:0] hs_cnt_r;
   logic [3:0] ls_cnt_r;
   logic [3:0] lim;
   assign lim = slow_in ? 4'h8 : 4'h1;
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         hs_cnt_r <= 4'h0;
         ls_cnt_r <= 4'h0;
      end else begin
         hs_cnt_r <= gate_in.hs_on ? 4'h0 : (hs_cnt_r < lim ? hs_cnt_r + 4'h1 : hs_cnt_r);
         ls_cnt_r <= gate_in.ls_on ? 4'h0 : (ls_cnt_r < lim ? ls_cnt_r + 4'h1 : ls_cnt_r);
      end
   end
   assign high_gate_off_out = !gate_in.hs_on && hs_cnt_r >= lim;
   assign low_gate_off_out  = !gate_in.ls_on && ls_cnt_r >= lim;
endmodule
`default_nettype wire

// ===== half_bridge_chop_control_tb.sv
// Self-checking bench for hbcc_top with shortened timing parameters.
// Assumes the FET model answers the gate-off pins.
`timescale 1ns/1ps
`default_nettype none
module half_bridge_chop_control_tb;
   import hbcc_pkg::*;
   localparam int TOFF_CYC = 500 / 50;
   localparam logic [9:0] GAIN_REF [4] = '{10'h064, 10'h0c6, 10'h18a, 10'h30c};
   localparam logic [9:0] HS_REF [6] = '{10'h00a, 10'h014, 10'h032, 10'h09b, 10'h0d2, 10'h104};
   localparam logic [9:0] LS_REF [6] = '{10'h00a, 10'h014, 10'h02d, 10'h082, 10'h0b4, 10'h0e1};
   logic          clk    = 1'b0;
   logic          arst_n = 1'b0;
   logic          slow   = 1'b0;
   hbcc_pins_t    pin_r  = '0;
   hbcc_pins_t    pins_w;
   logic [AW-1:0] addr   = '0;
   logic [DW-1:0] wdata  = '0;
   logic          wr     = 1'b0;
   logic          rd     = 1'b0;
   logic [DW-1:0] rdata;
   logic          dig_en, ana_en, f_low, f_oe, hiz, hgo, lgo;
   hbcc_gate_t    gate;
   logic [1:0]    gcode;
   logic [9:0]    gx10, hsrc, lsrc, hsnk, lsnk;
   logic [31:0]   rv;
   int            fail_count = 0;
   int            num_checks = 0;
   int            cyc = 0;
   int            n;
   always #25 clk = ~clk;
   assign pins_w = {pin_r[11:5], hgo, lgo, pin_r[2:0]};
   hbcc_top #(.TOFF_T_NS(500), .BLANK_T_NS(200), .DRIVE_T_NS(200), .DEAD_T_NS(100),
      .PWR_T_NS(100)) dut (.core_clk_in(clk), .arst_n_in(arst_n), .pins_in(pins_w),
      .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
      .reg_rdata_out(rdata), .digital_regulator_en_out(dig_en),
      .analog_regulator_en_out(ana_en), .gate_out(gate), .fault_indicator_low_out(f_low),
      .fault_indicator_low_oe_out(f_oe), .amp_hiz_out(hiz), .gain_code_out(gcode),
      .gain_x10_out(gx10), .hs_source_ma_out(hsrc), .ls_source_ma_out(lsrc),
      .hs_sink_ma_out(hsnk), .ls_sink_ma_out(lsnk));
   hbcc_fet_model u_fet (.clk_in(clk), .rst_n_in(arst_n), .slow_in(slow), .gate_in(gate),
      .high_gate_off_out(hgo), .low_gate_off_out(lgo));
   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         finish_test();
      end
   end
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wr_reg(input logic [AW-1:0] a, input logic [DW-1:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [AW-1:0] a);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      rv = rdata;
   endtask
   // Inputs {first, second, compare}
   task automatic drive(input logic [2:0] v);
      @(posedge clk);
      pin_r.first_control_input  <= v[2];
      pin_r.second_control_input <= v[1];
      pin_r.chop_compare         <= v[0];
   endtask
   task automatic wait_gate(input string name, input logic hs, input logic ls);
      n = 0;
      while (n < 60 && !(gate.hs_on === hs && gate.ls_on === ls)) begin
         @(negedge clk);
         n++;
      end
      check(name, 32'({gate.hs_on, gate.ls_on}), 32'({hs, ls}));
   endtask
   task automatic wait_run();
      n = 0;
      while (n < 60 && ana_en !== 1'b1) begin
         @(negedge clk);
         n++;
      end
      check("dig_en", 32'({dig_en, ana_en}), 32'h3);
   endtask
   initial begin
      pin_r.sleep_n = 1'b1;
      repeat (8) @(posedge clk);
      arst_n <= 1'b1;
      wait_run();
      rd_reg(REG_CTRL);
      check("ctrl_reset", rv, 32'h1);
      rd_reg(REG_STATUS);
      check("mode_reg", 32'(rv[ST_MODE_BIT]), 32'h0);
      wr_reg(8'h08, 32'hffffffff);
      rd_reg(8'h08);
      check("unmapped", rv, 32'h0);
      for (int g = 0; g < 4; g++) begin
         wr_reg(REG_CTRL, 32'(g));
         repeat (3) @(negedge clk);
         check("gain_x10", 32'(gx10), 32'(GAIN_REF[g]));
      end
      for (int l = 0; l < 7; l++) begin
         @(posedge clk);
         pin_r.gate_current_select <= 3'(l);
         repeat (5) @(negedge clk);
         check("hs_src", 32'(hsrc), 32'(HS_REF[l > 5 ? 5 : l]));
         check("ls_snk", 32'(lsnk), 32'({LS_REF[l > 5 ? 5 : l], 1'b0}));
      end
      wr_reg(REG_CTRL, 32'h5);
      drive(3'b100);
      wait_gate("hs_on", 1'b1, 1'b0);
      // Compare stays high: blanking gates re-chop
      drive(3'b101);
      n = 0;
      while (gate.ls_on !== 1'b1 && n < 200) begin
         @(negedge clk);
         n++;
      end
      check("chop_brake", 32'(gate.ls_on), 32'h1);
      check("amp_hiz", 32'(hiz), 32'h1);
      while (gate.hs_on !== 1'b1 && n < 200) begin
         @(negedge clk);
         n++;
      end
      check("toff_len", 32'(n >= TOFF_CYC && n < TOFF_CYC + 20), 32'h1);
      check("amp_drive", 32'(hiz), 32'h0);
      drive(3'b110);
      wait_gate("both_high", 1'b0, 1'b1);
      drive(3'b000);
      wait_gate("tri_state", 1'b0, 1'b0);
      drive(3'b010);
      repeat (6) @(negedge clk);
      check("illegal", 32'({f_oe, gate.hs_on, gate.ls_on}), 32'h4);
      drive(3'b000);
      @(posedge clk);
      pin_r.sense_overcurrent <= 1'b1;
      repeat (6) @(negedge clk);
      check("ocp_pin", 32'(f_oe), 32'h1);
      @(posedge clk);
      pin_r.sense_overcurrent <= 1'b0;
      pin_r.ext_fault         <= 1'b1;
      repeat (6) @(negedge clk);
      check("ext_fault", 32'({f_oe, gate.hs_on, gate.ls_on}), 32'h4);
      @(posedge clk);
      pin_r.ext_fault <= 1'b0;
      rd_reg(REG_STATUS);
      check("sticky", 32'(rv[4:3]), 32'h3);
      wr_reg(REG_STATUS, 32'h18);
      rd_reg(REG_STATUS);
      check("sticky_clr", 32'({f_oe, rv[4:3]}), 32'h0);
      @(posedge clk);
      pin_r.mode_strap_high <= 1'b1;
      rd_reg(REG_STATUS);
      check("strap_hold", 32'(rv[ST_MODE_BIT]), 32'h0);
      @(posedge clk);
      pin_r.sleep_n <= 1'b0;
      repeat (10) @(negedge clk);
      check("sleep_off", 32'({dig_en, ana_en}), 32'h0);
      @(posedge clk);
      pin_r.sleep_n <= 1'b1;
      wait_run();
      rd_reg(REG_STATUS);
      check("strap_wake", 32'(rv[ST_MODE_BIT]), 32'h1);
      wait_gate("unreg_low", 1'b0, 1'b1);
      slow <= 1'b1;
      drive(3'b101);
      wait_gate("unreg_high", 1'b1, 1'b0);
      n = 0;
      repeat (30) begin
         @(negedge clk);
         n += int'(gate.ls_on !== 1'b0);
      end
      check("no_chop", 32'(n), 32'h0);
      drive(3'b000);
      wait_gate("slow_low", 1'b0, 1'b1);
      finish_test();
   end
endmodule
`default_nettype wire
